// >>> rcf_receive_cell_processor.sv
// Receive cell processor: delineation, header check, filter, counters, FIFO
//
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module rcf_receive_cell_processor
	import rcf_pkg::*;
#(
	parameter int FIFO_CELLS = 4,
	parameter int GFC_DIV = GFC_DIV_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire rcf_byte_t rx_in,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic fifo_read_clock,
	input wire logic fifo_read_enable_n,
	output logic start_of_cell_flag,
	output logic cell_available_flag,
	output logic [1:0] receive_word_parity,
	output logic [15:0] receive_word,
	output logic flow_control_serial_out,
	output logic cell_position_pulse,
	output logic overrun_irq
);
	localparam int PW = $clog2(FIFO_CELLS);
	localparam logic [15:0] DIV_LAST = 16'(GFC_DIV - 1);
	localparam logic [PW:0] FULL = (PW + 1)'(FIFO_CELLS);

	if (FIFO_CELLS < 2 || (FIFO_CELLS & (FIFO_CELLS - 1)) != 0) begin : g_bad_depth
		$error("FIFO_CELLS must be a power of two of at least 2");
	end
	if (GFC_DIV < 2 || GFC_DIV > 65536) begin : g_bad_div
		$error("GFC_DIV must lie in 2 to 65536");
	end

	logic rst_s1_q;
	logic rst_n_q;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_q <= 1'h0;
			rst_n_q <= 1'h0;
		end else begin
			rst_s1_q <= 1'h1;
			rst_n_q <= rst_s1_q;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n_q);

	// Register slave: one wait cycle, then an answer
	logic [31:0] ctrl_q;
	logic [31:0] pat_q;
	logic [31:0] mask_q;
	logic bus_wr;
	logic latch_req;
	logic ovr_q;
	assign bus_wr = avs_write && !avs_waitrequest;
	assign latch_req = bus_wr && avs_address == REG_LATCH;

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			avs_waitrequest <= 1'h1;
		end else if (!avs_waitrequest) begin
			avs_waitrequest <= 1'h1;
		end else if (avs_read || avs_write) begin
			avs_waitrequest <= 1'h0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ctrl_q <= CTRL_RESET;
			pat_q <= 32'h0000_0000;
			mask_q <= 32'h0000_0000;
		end else if (bus_wr) begin
			if (avs_address == REG_CTRL) ctrl_q <= avs_writedata & CTRL_WMASK;
			if (avs_address == REG_PATTERN) pat_q <= avs_writedata;
			if (avs_address == REG_MASK) mask_q <= avs_writedata;
		end
	end

	logic filter_en;
	logic hcs_en;
	logic fmt16;
	logic [3:0] m_count;
	assign filter_en = ctrl_q[CTRL_FILTER];
	assign hcs_en = ctrl_q[CTRL_HCS];
	assign fmt16 = ctrl_q[CTRL_FMT16];
	assign m_count = 4'h1 << ctrl_q[CTRL_MSEL +: 2];

	// Cell delineation on the byte stream
	logic [39:0] sh_q;
	logic [39:0] sh_d;
	rcf_hcs_res_t chk;
	logic [5:0] idx_q;
	rcf_delin_t dl_q;
	logic [2:0] run_q;
	assign sh_d = {sh_q[31:0], rx_in.data};

	rcf_hcs_check u_chk (
		.hdr_in(sh_d),
		.res(chk)
	);

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) sh_q <= 40'h00_0000_0000;
		else if (rx_in.valid) sh_q <= sh_d;
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			dl_q <= DL_HUNT;
			idx_q <= 6'h00;
			run_q <= 3'h0;
		end else if (rx_in.valid) begin
			idx_q <= (idx_q == CELL_LAST) ? 6'h00 : idx_q + 6'h01;
			case (dl_q)
				DL_HUNT: begin
					if (chk.zero) begin
						dl_q <= DL_PRESYNC;
						idx_q <= PAY_IDX;
						run_q <= 3'h0;
					end
				end
				DL_PRESYNC: begin
					if (idx_q == HCS_IDX) begin
						if (!chk.zero) begin
							dl_q <= DL_HUNT;
						end else if (run_q == DELTA_LAST) begin
							dl_q <= DL_SYNC;
							run_q <= 3'h0;
						end else begin
							run_q <= run_q + 3'h1;
						end
					end
				end
				DL_SYNC: begin
					if (idx_q == HCS_IDX) begin
						if (chk.zero) begin
							run_q <= 3'h0;
						end else if (run_q == SYNC_LOSS_LAST) begin
							dl_q <= DL_HUNT;
							run_q <= 3'h0;
						end else begin
							run_q <= run_q + 3'h1;
						end
					end
				end
				default: dl_q <= DL_HUNT;
			endcase
		end
	end

	// Header verification and filtering per cell
	logic live_q;
	logic drop_q;
	logic hdr_evt;
	logic pay_evt;
	logic commit;
	logic keep;
	logic cor_e;
	logic unc_e;
	logic match;
	rcf_hcs_t hv_q;
	rcf_hcs_t hv_d;
	logic [3:0] good_q;
	logic [3:0] good_d;
	logic [31:0] hdr_w;
	assign hdr_evt = live_q && rx_in.valid && idx_q == HCS_IDX && dl_q == DL_SYNC;
	assign pay_evt = live_q && !drop_q && rx_in.valid && idx_q > HCS_IDX;
	assign commit = pay_evt && idx_q == CELL_LAST;
	assign hdr_w = hcs_en ? chk.hdr : sh_d[39:8];
	assign match = ((hdr_w ^ pat_q) & mask_q) == 32'h0000_0000;

	always_comb begin
		hv_d = hv_q;
		good_d = good_q;
		keep = 1'h1;
		cor_e = 1'h0;
		unc_e = 1'h0;
		if (hdr_evt) begin
			if (hv_q == HV_CORR) begin
				if (!chk.zero) begin
					hv_d = HV_DET;
					good_d = 4'h0;
				end
				if (chk.single) begin
					cor_e = 1'h1;
				end else if (!chk.zero) begin
					unc_e = 1'h1;
					keep = !hcs_en;
				end
			end else if (!chk.zero) begin
				unc_e = 1'h1;
				keep = !hcs_en;
				good_d = 4'h0;
			end else if (good_q + 4'h1 == m_count) begin
				hv_d = HV_CORR;
				good_d = 4'h0;
			end else begin
				good_d = good_q + 4'h1;
			end
			if (filter_en && match) keep = 1'h0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			hv_q <= HV_CORR;
			good_q <= 4'h0;
		end else if (dl_q != DL_SYNC) begin
			hv_q <= HV_CORR;
			good_q <= 4'h0;
		end else begin
			hv_q <= hv_d;
			good_q <= good_d;
		end
	end

	// A cell only starts at a boundary seen while synced
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			live_q <= 1'h0;
			drop_q <= 1'h0;
		end else if (dl_q != DL_SYNC) begin
			live_q <= 1'h0;
		end else if (rx_in.valid && idx_q == 6'h00) begin
			live_q <= 1'h1;
			drop_q <= 1'h0;
		end else if (hdr_evt) begin
			drop_q <= !keep;
		end
	end

	// Counters with latch; the latch never loses a coincident event
	logic [2:0] evt;
	assign evt = {commit, unc_e, cor_e};
	for (genvar k = 0; k < 3; k++) begin : g_cnt
		localparam logic [20:0] MAX = (k == 2) ? CNT_CELL_MAX : CNT_ERR_MAX;
		logic [20:0] live_q;
		logic [20:0] held_q;
		always_ff @(posedge sys_clk or negedge rst_n_q) begin
			if (!rst_n_q) begin
				live_q <= 21'h000000;
				held_q <= 21'h000000;
			end else if (latch_req) begin
				held_q <= live_q;
				live_q <= {20'h00000, evt[k]};
			end else if (evt[k] && live_q != MAX) begin
				live_q <= live_q + 21'h000001;
			end
		end
	end

	// Cell store, one slot per cell; dropped cells never advance the pointer
	logic [15:0] mem_q [FIFO_CELLS][CELL_BYTES];
	logic [PW:0] wp_q;
	logic [PW:0] rp_q;
	logic [PW:0] cnt;
	logic [PW-1:0] ws;
	logic [5:0] pofs;
	logic [5:0] pw16;
	logic ovr_evt;
	assign ws = wp_q[PW-1:0];
	assign cnt = wp_q - rp_q;
	assign ovr_evt = commit && cnt == FULL;
	assign pofs = idx_q - PAY_IDX;
	assign pw16 = {1'h0, pofs[5:1]} + PAY_W16;

	always_ff @(posedge sys_clk) begin
		if (hdr_evt) begin
			if (fmt16) begin
				mem_q[ws][0] <= hdr_w[31:16];
				mem_q[ws][1] <= hdr_w[15:0];
				mem_q[ws][2] <= {sh_d[7:0], !chk.zero, chk.single, 6'h00};
			end else begin
				mem_q[ws][0] <= {8'h00, hdr_w[31:24]};
				mem_q[ws][1] <= {8'h00, hdr_w[23:16]};
				mem_q[ws][2] <= {8'h00, hdr_w[15:8]};
				mem_q[ws][3] <= {8'h00, hdr_w[7:0]};
				mem_q[ws][4] <= {8'h00, sh_d[7:0]};
			end
		end else if (pay_evt) begin
			if (!fmt16) mem_q[ws][idx_q] <= {8'h00, rx_in.data};
			else if (!pofs[0]) mem_q[ws][pw16][15:8] <= rx_in.data;
			else mem_q[ws][pw16][7:0] <= rx_in.data;
		end
	end

	// Overrun drops everything stored rather than stalling the line
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) wp_q <= '0;
		else if (ovr_evt) wp_q <= '0;
		else if (commit) wp_q <= wp_q + 1'h1;
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) ovr_q <= 1'h0;
		else if (ovr_evt) ovr_q <= 1'h1;
		else if (bus_wr && avs_address == REG_STATUS && avs_writedata[STAT_OVR])
			ovr_q <= 1'h0;
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) overrun_irq <= 1'h0;
		else overrun_irq <= ovr_q && ctrl_q[CTRL_OVR_IE];
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && avs_waitrequest) begin
			case (avs_address)
				REG_CTRL: avs_readdata <= ctrl_q;
				REG_PATTERN: avs_readdata <= pat_q;
				REG_MASK: avs_readdata <= mask_q;
				REG_STATUS: avs_readdata <= 32'({cnt, ovr_q, hv_q, dl_q});
				REG_CNT_COR: avs_readdata <= 32'(g_cnt[0].held_q);
				REG_CNT_UNC: avs_readdata <= 32'(g_cnt[1].held_q);
				REG_CNT_CELL: avs_readdata <= 32'(g_cnt[2].held_q);
				default: avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	// Read port: pins pass three flops, a level counts once two agree
	logic [2:0] rck_q;
	logic [2:0] ren_q;
	logic rck_lvl_q;
	logic ren_lvl_q;
	logic rd_edge;
	logic rd_ok;
	logic [5:0] rw_q;
	logic [5:0] rw_last;
	logic fin;
	assign rd_edge = rck_q[2] && rck_q[1] && !rck_lvl_q;
	assign rd_ok = rd_edge && !ren_lvl_q && cnt != '0;
	assign rw_last = fmt16 ? LAST_W16 : CELL_LAST;
	assign fin = rd_ok && rw_q == rw_last;

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rck_q <= 3'h0;
			ren_q <= 3'h7;
			rck_lvl_q <= 1'h0;
			ren_lvl_q <= 1'h1;
		end else begin
			rck_q <= {rck_q[1:0], fifo_read_clock};
			ren_q <= {ren_q[1:0], fifo_read_enable_n};
			if (rck_q[2] == rck_q[1]) rck_lvl_q <= rck_q[2];
			if (ren_q[2] == ren_q[1]) ren_lvl_q <= ren_q[2];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rp_q <= '0;
			rw_q <= 6'h00;
		end else if (ovr_evt) begin
			rp_q <= '0;
			rw_q <= 6'h00;
		end else if (fin) begin
			rp_q <= rp_q + 1'h1;
			rw_q <= 6'h00;
		end else if (rd_ok) begin
			rw_q <= rw_q + 6'h01;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			receive_word <= 16'h0000;
			receive_word_parity <= 2'h3;
			start_of_cell_flag <= 1'h0;
			cell_available_flag <= 1'h0;
		end else if (rd_edge) begin
			start_of_cell_flag <= rd_ok && rw_q == 6'h00;
			cell_available_flag <= (cnt - (PW + 1)'(fin)) != '0;
			if (rd_ok) begin
				receive_word <= mem_q[rp_q[PW-1:0]][rw_q];
				receive_word_parity <= {~^mem_q[rp_q[PW-1:0]][rw_q][15:8],
					~^mem_q[rp_q[PW-1:0]][rw_q][7:0]};
			end
		end
	end

	// Flow control serial stream paced by a divider enable
	logic [3:0] gfc_q;
	logic [3:0] gfc_nx;
	logic [15:0] div_q;
	logic [1:0] gpos_q;
	logic gen;
	assign gen = div_q == DIV_LAST;
	for (genvar b = 0; b < 4; b++) begin : g_gfc
		assign gfc_nx[b] = ctrl_q[CTRL_GFC_HOLD + b] ? gfc_q[b] : hdr_w[28 + b];
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) gfc_q <= 4'h0;
		else if (hdr_evt) gfc_q <= gfc_nx;
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			div_q <= 16'h0000;
			gpos_q <= 2'h0;
		end else begin
			div_q <= gen ? 16'h0000 : div_q + 16'h0001;
			if (gen) gpos_q <= gpos_q + 2'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			flow_control_serial_out <= 1'h0;
			cell_position_pulse <= 1'h0;
		end else if (dl_q != DL_SYNC) begin
			flow_control_serial_out <= 1'h0;
			cell_position_pulse <= 1'h0;
		end else if (gen) begin
			flow_control_serial_out <= gfc_q[2'h3 - gpos_q];
			cell_position_pulse <= gpos_q == 2'h0;
		end
	end

	sequence s_err_in_corr;
		hdr_evt && hv_q == HV_CORR && !chk.zero;
	endsequence
	sequence s_mth_good;
		hdr_evt && hv_q == HV_DET && chk.zero && good_q + 4'h1 == m_count;
	endsequence

	a_fill_in_sync: assert property (commit |-> dl_q == DL_SYNC && live_q)
		else $error("cell committed outside sync");
	a_filter_drop: assert property (hdr_evt && filter_en && match |=> drop_q)
		else $error("matching header not dropped");
	a_coset_check: assert property (hdr_evt && chk.zero |->
		(rcf_crc32(sh_d[39:8]) ^ HCS_COSET) == sh_d[7:0])
		else $error("header check disagrees with CRC and coset");
	a_enter_detect: assert property (s_err_in_corr |=> hv_q == HV_DET)
		else $error("error in correction mode did not enter detection");
	a_detect_drop: assert property (hdr_evt && hv_q == HV_DET && !chk.zero &&
		hcs_en |=> (drop_q && !commit) [*8])
		else $error("errored cell kept in detection mode");
	a_mth_kept: assert property (s_mth_good ##0 !filter_en |=>
		hv_q == HV_CORR && !drop_q)
		else $error("Mth good cell not kept or mode not restored");
	a_cor_count: assert property (s_err_in_corr ##0 chk.single && !latch_req &&
		g_cnt[0].live_q != CNT_ERR_MAX |=>
		g_cnt[0].live_q == $past(g_cnt[0].live_q) + 21'h000001)
		else $error("corrected error not counted");
	a_latch_zero: assert property (latch_req && !commit |=>
		g_cnt[2].live_q == 21'h000000 && g_cnt[2].held_q == $past(g_cnt[2].live_q))
		else $error("cell counter latch wrong");
	a_sync_loss: assert property (rx_in.valid && idx_q == HCS_IDX && dl_q == DL_SYNC
		&& !chk.zero && run_q == SYNC_LOSS_LAST |=> dl_q == DL_HUNT)
		else $error("sync not lost after seventh bad check");
	a_ovr_reset: assert property (ovr_evt |=> wp_q == '0 && rp_q == '0 && ovr_q)
		else $error("overrun did not reset FIFO");
	a_empty_read: assert property (rd_edge && cnt == '0 && !commit |=>
		$stable(rp_q) && $stable(rw_q) && !start_of_cell_flag)
		else $error("read of empty FIFO changed state");
	a_gfc_low: assert property (dl_q != DL_SYNC |=> !flow_control_serial_out)
		else $error("flow control output not low out of sync");
	a_avail_empty: assert property (rd_edge && cnt == '0 |=> !cell_available_flag)
		else $error("cell available with empty FIFO");
endmodule : rcf_receive_cell_processor

// >>> rcf_pkg.sv
// Constants and types of the ATM receive cell filter FIFO
package rcf_pkg;
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_PATTERN = 5'h04;
	localparam logic [4:0] REG_MASK = 5'h08;
	localparam logic [4:0] REG_STATUS = 5'h0C;
	localparam logic [4:0] REG_LATCH = 5'h10;
	localparam logic [4:0] REG_CNT_COR = 5'h14;
	localparam logic [4:0] REG_CNT_UNC = 5'h18;
	localparam logic [4:0] REG_CNT_CELL = 5'h1C;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_03FF;
	localparam int CTRL_FILTER = 0;
	localparam int CTRL_HCS = 1;
	localparam int CTRL_MSEL = 2;
	localparam int CTRL_FMT16 = 4;
	localparam int CTRL_GFC_HOLD = 5;
	localparam int CTRL_OVR_IE = 9;
	localparam int STAT_OVR = 3;
	localparam logic [7:0] HCS_POLY = 8'h07;
	localparam logic [7:0] HCS_COSET = 8'h55;
	localparam logic [5:0] HCS_IDX = 6'h04;
	localparam logic [5:0] PAY_IDX = 6'h05;
	localparam logic [5:0] CELL_LAST = 6'h34;
	localparam logic [5:0] LAST_W16 = 6'h1A;
	localparam logic [5:0] PAY_W16 = 6'h03;
	localparam int CELL_BYTES = 53;
	localparam logic [2:0] SYNC_LOSS_LAST = 3'h6;
	localparam logic [2:0] DELTA_LAST = 3'h5;
	localparam logic [20:0] CNT_ERR_MAX = 21'h000FFF;
	localparam logic [20:0] CNT_CELL_MAX = 21'h1FFFFF;
	localparam int SYS_CLK_NS = 10;
	localparam int GFC_BIT_NS = 1000;
	localparam int GFC_DIV_CYC = GFC_BIT_NS / SYS_CLK_NS;

	typedef enum logic [1:0] {
		DL_HUNT = 2'h0,
		DL_PRESYNC = 2'h1,
		DL_SYNC = 2'h3
	} rcf_delin_t;

	typedef enum logic {
		HV_CORR = 1'h0,
		HV_DET = 1'h1
	} rcf_hcs_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} rcf_byte_t;

	typedef struct packed {
		logic zero;
		logic single;
		logic [31:0] hdr;
	} rcf_hcs_res_t;

	function automatic logic [7:0] rcf_crc32(input logic [31:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 31; i >= 0; i--) begin
			c = {c[6:0], 1'h0} ^ ((c[7] ^ d[i]) ? HCS_POLY : 8'h00);
		end
		return c;
	endfunction : rcf_crc32
endpackage : rcf_pkg

// >>> rcf_hcs_check.sv
// Header check syndrome and single-bit correction
`timescale 1ns/10ps
module rcf_hcs_check
	import rcf_pkg::*;
(
	input wire logic [39:0] hdr_in,
	output rcf_hcs_res_t res
);
	logic [7:0] syn;
	logic [39:0] hit;
	logic [39:0] fixed;

	assign syn = rcf_crc32(hdr_in[39:8]) ^ hdr_in[7:0] ^ HCS_COSET;
	for (genvar i = 0; i < 40; i++) begin : g_bit
		localparam logic [39:0] E = 40'h1 << i;
		localparam logic [7:0] S = rcf_crc32(E[39:8]) ^ E[7:0];
		assign hit[i] = (syn == S);
	end
	assign fixed = hdr_in ^ hit;
	assign res.zero = (syn == 8'h00);
	assign res.single = |hit;
	assign res.hdr = fixed[39:8];
endmodule : rcf_hcs_check

// >>> rcf_reader_model.sv
// Reader model: ATM layer device pulling words over the FIFO port
`timescale 1ns/10ps
module rcf_reader_model
	import rcf_pkg::*;
(
	output logic fifo_read_clock,
	output logic fifo_read_enable_n,
	input wire logic start_of_cell_flag,
	input wire logic [1:0] receive_word_parity,
	input wire logic [15:0] receive_word
);
	logic [15:0] got [53];
	logic sof [53];
	int par_bad = 0;
	// Odd start offset keeps the reader clock out of step with sys_clk
	initial begin
		fifo_read_clock = 1'b0;
		fifo_read_enable_n = 1'b1;
		#3;
		forever #62.5 fifo_read_clock = ~fifo_read_clock;
	end
	// Enable lands a rise late and a word taken at one rise shows at the next, so sampling lags by two
	task automatic read_words(input int n);
		for (int i = 0; i <= n + 1; i++) begin
			@(posedge fifo_read_clock);
			if (i >= 2) begin
				got[i - 2] = receive_word;
				sof[i - 2] = start_of_cell_flag;
				if (^{receive_word_parity[1], receive_word[15:8]} !== 1'b1)
					par_bad++;
				if (^{receive_word_parity[0], receive_word[7:0]} !== 1'b1)
					par_bad++;
			end
			fifo_read_enable_n <= (i >= n);
		end
	endtask : read_words
endmodule : rcf_reader_model

// >>> tb.sv
// Testbench of the receive cell processor: bus, line stream and reader
`timescale 1ns/10ps
module tb
	import rcf_pkg::*;
;
	localparam int GDIV = 4;
	localparam logic [31:0] HD = 32'h0123_4560;
	logic sys_clk, rst_n, avs_read, avs_write, avs_waitrequest;
	rcf_byte_t rx_in;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rdv;
	logic fifo_read_clock, fifo_read_enable_n, start_of_cell_flag;
	logic cell_available_flag, flow_control_serial_out;
	logic cell_position_pulse, overrun_irq;
	logic [1:0] receive_word_parity;
	logic [15:0] receive_word, keep_w;
	logic [7:0] cb [53];
	int num_errors = 0;
	int check_count = 0;
	rcf_receive_cell_processor #(.FIFO_CELLS(4), .GFC_DIV(GDIV)) u_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .rx_in(rx_in),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.fifo_read_clock(fifo_read_clock),
		.fifo_read_enable_n(fifo_read_enable_n),
		.start_of_cell_flag(start_of_cell_flag),
		.cell_available_flag(cell_available_flag),
		.receive_word_parity(receive_word_parity),
		.receive_word(receive_word),
		.flow_control_serial_out(flow_control_serial_out),
		.cell_position_pulse(cell_position_pulse),
		.overrun_irq(overrun_irq)
	);
	rcf_reader_model u_rdr (
		.fifo_read_clock(fifo_read_clock),
		.fifo_read_enable_n(fifo_read_enable_n),
		.start_of_cell_flag(start_of_cell_flag),
		.receive_word_parity(receive_word_parity),
		.receive_word(receive_word)
	);
	task automatic end_sim();
		$display("errors=%0d checks=%0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_sim
	task automatic tmo();
		num_errors++;
		end_sim();
	endtask : tmo
	task automatic chk(input logic [31:0] g, e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rdv = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (avs_waitrequest !== 1'b0) tmo();
	endtask : bus
	task automatic rm(input logic [4:0] a, input logic [31:0] m, e);
		bus(1'b0, a, 32'h0);
		chk(rdv & m, e);
	endtask : rm
	task automatic cnt(input logic [31:0] c, u, n);
		bus(1'b1, REG_LATCH, 32'h0);
		rm(REG_CNT_COR, 32'hFFF, c);
		rm(REG_CNT_UNC, 32'hFFF, u);
		rm(REG_CNT_CELL, 32'h1F_FFFF, n);
	endtask : cnt
	function automatic logic [7:0] crc8(input logic [31:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 31; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction : crc8
	// Cell bytes kept in cb are the true ones; f flips header bits on the wire
	task automatic send(input logic [31:0] h, f, input logic [7:0] p);
		logic [31:0] t;
		t = h ^ f;
		cb[4] = crc8(h) ^ 8'h55;
		for (int i = 0; i < 53; i++) begin
			if (i < 4) cb[i] = h[31 - 8 * i -: 8];
			if (i > 4) cb[i] = p + 8'(i);
			@(posedge sys_clk);
			rx_in <= {1'b1, (i < 4) ? t[31 - 8 * i -: 8] : cb[i]};
		end
		@(posedge sys_clk);
		rx_in <= '0;
	endtask : send
	task automatic getc(input int n);
		int k;
		k = 0;
		while (cell_available_flag !== 1'b1 && k < 200) begin
			@(posedge sys_clk);
			k++;
		end
		if (k == 200) tmo();
		u_rdr.read_words(n);
	endtask : getc
	task automatic dr();
		repeat (30) @(posedge sys_clk);
		for (int j = 0; j < 6 && cell_available_flag === 1'b1; j++)
			u_rdr.read_words(53);
	endtask : dr
	task automatic cmp8();
		for (int i = 0; i < 53; i++) begin
			chk(u_rdr.got[i], {8'h00, cb[i]});
			chk(u_rdr.sof[i], i == 0);
		end
	endtask : cmp8
	task automatic gfc(input logic [3:0] g);
		int k;
		logic pv;
		k = 0;
		pv = 1'b1;
		while (!(pv === 1'b0 && cell_position_pulse === 1'b1) && k < 100) begin
			pv = cell_position_pulse;
			@(posedge sys_clk);
			k++;
		end
		if (k == 100) tmo();
		for (int b = 3; b >= 0; b--) begin
			@(posedge sys_clk);
			chk(flow_control_serial_out, g[b]);
			chk(cell_position_pulse, b == 3);
			repeat (GDIV - 1) @(posedge sys_clk);
		end
	endtask : gfc
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		rst_n = 1'b0;
		rx_in = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 5'h00;
		avs_writedata = 32'h0;
		repeat (10) @(posedge sys_clk);
		chk(cell_available_flag, 1'b0);
		chk(flow_control_serial_out, 1'b0);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rm(REG_STATUS, 32'h7, 32'h0);
		for (int i = 0; i < 11; i++) send(HD, 32'h0, 8'(i * 7));
		rm(REG_STATUS, 32'h7B, 32'h43);
		dr();
		bus(1'b1, REG_LATCH, 32'h0);
		send(HD, 32'h0, 8'h10);
		getc(53);
		cmp8();
		repeat (20) @(posedge sys_clk);
		chk(cell_available_flag, 1'b0);
		cnt(0, 0, 1);
		bus(1'b1, REG_CTRL, 32'h6);
		send(HD, 32'h0000_0100, 8'h20);
		getc(53);
		cmp8();
		rm(REG_STATUS, 32'h4, 32'h4);
		cnt(1, 0, 1);
		send(HD, 32'h0000_0300, 8'h30);
		send(HD, 32'h0, 8'h31);
		rm(REG_STATUS, 32'h4, 32'h4);
		send(HD, 32'h0, 8'h32);
		repeat (10) @(posedge sys_clk);
		rm(REG_STATUS, 32'h74, 32'h20);
		dr();
		cnt(0, 1, 2);
		bus(1'b1, REG_CTRL, 32'h3);
		bus(1'b1, REG_PATTERN, 32'h1);
		bus(1'b1, REG_MASK, 32'hFFFF_FFFF);
		send(32'h1, 32'h0, 8'h60);
		send(32'h0, 32'h0, 8'h61);
		send(32'h1000_0001, 32'h0, 8'h62);
		send(32'h3, 32'h0, 8'h63);
		send(HD, 32'h0000_0300, 8'h64);
		send(HD, 32'h0, 8'h65);
		repeat (10) @(posedge sys_clk);
		rm(REG_STATUS, 32'h74, 32'h40);
		dr();
		cnt(0, 1, 4);
		bus(1'b1, REG_CTRL, 32'h12);
		send(HD, 32'h0, 8'h40);
		getc(27);
		for (int k = 0; k < 27; k++)
			chk(u_rdr.got[k] & ((k == 2) ? 16'hFFC0 : 16'hFFFF),
				(k == 2) ? {cb[4], 8'h00} :
				{cb[2 * k - (k > 2)], cb[2 * k + 1 - (k > 2)]});
		chk(u_rdr.sof[0] && !u_rdr.sof[1], 1'b1);
		keep_w = u_rdr.got[26];
		bus(1'b1, REG_CTRL, 32'h2);
		u_rdr.read_words(1);
		chk(u_rdr.got[0], keep_w);
		chk(u_rdr.sof[0], 1'b0);
		send(HD, 32'h0, 8'h50);
		getc(53);
		cmp8();
		chk(u_rdr.par_bad, 0);
		bus(1'b1, REG_CTRL, 32'h202);
		for (int j = 0; j < 5; j++) send(HD, 32'h0, 8'(j));
		repeat (30) @(posedge sys_clk);
		rm(REG_STATUS, 32'h78, 32'h8);
		chk({overrun_irq, cell_available_flag}, 2'b10);
		bus(1'b1, REG_STATUS, 32'h8);
		rm(REG_STATUS, 32'h8, 32'h0);
		chk(overrun_irq, 1'b0);
		bus(1'b1, REG_CTRL, 32'h2);
		send(32'hA123_4560, 32'h0, 8'h70);
		send(32'hA123_4560, 32'h0, 8'h71);
		gfc(4'hA);
		bus(1'b1, REG_CTRL, 32'h1E2);
		send(32'h5123_4560, 32'h0, 8'h72);
		send(32'h5123_4560, 32'h0, 8'h73);
		gfc(4'hA);
		bus(1'b1, REG_CTRL, 32'h2);
		dr();
		for (int j = 0; j < 7; j++) send(HD, 32'h0101_0101, 8'(j));
		rm(REG_STATUS, 32'h2, 32'h0);
		chk(flow_control_serial_out, 1'b0);
		send(HD, 32'h0, 8'h80);
		repeat (30) @(posedge sys_clk);
		chk(cell_available_flag, 1'b0);
		end_sim();
	end
endmodule : tb
